// ===== rtl/ief_map.svh
`ifndef IEF_MAP_SVH
`define IEF_MAP_SVH

// Register byte addresses
`define IEF_OFF_CONTROL 8'h00
`define IEF_OFF_PEN_ONE 8'h04
`define IEF_OFF_PEN_TWO 8'h08
`define IEF_OFF_PFL_ONE 8'h0C
`define IEF_OFF_PFL_TWO 8'h10
`define IEF_OFF_OPTION 8'h14
`define IEF_OFF_STATUS 8'h18

// Interrupt control field positions
`define IEF_BIT_GLOBAL_EN 7
`define IEF_BIT_PERIPH_EN 6
`define IEF_BIT_TIMER_EN 5
`define IEF_BIT_EXTE 4
`define IEF_BIT_CDE 3
`define IEF_BIT_T0F 2
`define IEF_BIT_EXTF 1
`define IEF_BIT_CDF 0

// Option register field positions
`define IEF_BIT_EDGE 0
`define IEF_BIT_ANALOG 1

// Status register field positions
`define IEF_BIT_ST_REQ 0
`define IEF_BIT_ST_WAIT 1
`define IEF_BIT_ST_ARM 2
`define IEF_BIT_ST_PIN 3

// Implemented bits of the peripheral enable and flag registers
`define IEF_MASK_ONE 8'h73
`define IEF_MASK_TWO 8'hB2

// Reset values
`define IEF_RST_CONTROL 8'h00
`define IEF_RST_PERIPH 8'h00
`define IEF_RST_OPTION 8'h02

// Timing
`define IEF_CLK_PER_TCY 4
`define IEF_LATENCY_TCY 3
`define IEF_VECTOR 13'h0004

`endif

// ===== rtl/ief_pkg.sv
package ief_pkg;

    typedef enum logic [1:0] {
        IEF_Q1,
        IEF_Q2,
        IEF_Q3,
        IEF_Q4
    } ief_phase_type;

    typedef enum logic {
        IEF_IDLE,
        IEF_WAIT
    } ief_take_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ief_apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ief_apb_rsp_type;

    typedef struct packed {
        logic timer0_rollover;
        logic change_detect;
        logic [7:0] periph_one;
        logic [7:0] periph_two;
    } ief_evt_type;

    typedef struct packed {
        logic irq_req;
        logic vector_load;
        logic [12:0] vector;
        logic wake;
    } ief_core_type;

endpackage

// ===== rtl/ief_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ief_sync (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule
`default_nettype wire

// ===== rtl/ief_phase.sv
`timescale 1ns/10ps
`default_nettype none
`include "ief_map.svh"
module ief_phase
    import ief_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    output ief_phase_type phase_o,
    output logic q1_o,
    output logic q4_o
);
    ief_phase_type phase_q;
    ief_phase_type phase_d;

    // One instruction cycle is four clocks, Q1 through Q4
    always_comb begin
        phase_d = IEF_Q1;
        unique case (phase_q)
            IEF_Q1: phase_d = IEF_Q2;
            IEF_Q2: phase_d = IEF_Q3;
            IEF_Q3: phase_d = IEF_Q4;
            IEF_Q4: phase_d = IEF_Q1;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            phase_q <= IEF_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase_o = phase_q;
    assign q1_o = (phase_q == IEF_Q1);
    assign q4_o = (phase_q == IEF_Q4);
endmodule
`default_nettype wire

// ===== rtl/ief_top.sv
// Function
// - External pin edge, polarity chosen by select
// - Selected edge sets external pin flag
// - Pin enable low blocks pin request
// - Pin wakes sleep only if enabled before
// - Analog pin reads zero, never interrupts
// - Pin flag set in Q4-Q1, sampled Q1
// - Take latency three instruction cycles after sample
// - Flags set regardless of any enable
// - Global enable bit 7 gates every request, not sleep wake
// - Peripheral enable bit 6 gates peripherals
// - Timer0, pin, change enables at 5,4,3
// - Timer0 rollover sets flag bit 2
// - Change detect sets flag bit 0
// - Control register read/write, pin flag bit 1
// - Enable one bits 6,5,4,1,0; others zero
// - Enable two bits 7,5,4,1; others zero
// - Taking clears global enable, vector 0004h
// - Flags one match enable one positions
// - Flags two match enable two positions
`timescale 1ns/10ps
`default_nettype none
`include "ief_map.svh"
module ief_top
    import ief_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire ief_apb_req_type apb_i,
    output ief_apb_rsp_type apb_o,
    input wire logic ext_irq_pin_i,
    input wire ief_evt_type evt_i,
    input wire logic sleep_i,
    input wire logic return_from_irq_i,
    output ief_core_type core_o,
    output logic pin_level_o
);
    // =====================================================
    // Helpers
    // =====================================================
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
        addr_hit = (addr == off);
    endfunction

    function automatic logic any_term(input logic [7:0] flags, input logic [7:0] enables);
        any_term = |(flags & enables);
    endfunction

    // =====================================================
    // Instruction cycle phases and pin synchroniser
    // =====================================================
    logic q1;
    logic q4;
    logic pin_sync;

    ief_phase u_phase (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .phase_o(),
        .q1_o(q1),
        .q4_o(q4)
    );

    ief_sync u_pin_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .async_i(ext_irq_pin_i),
        .sync_o(pin_sync)
    );

    // =====================================================
    // Registers
    // =====================================================
    logic [7:0] control_q;
    logic [7:0] control_d;
    logic [7:0] pen_one_q;
    logic [7:0] pen_one_d;
    logic [7:0] pen_two_q;
    logic [7:0] pen_two_d;
    logic [7:0] pfl_one_q;
    logic [7:0] pfl_one_d;
    logic [7:0] pfl_two_q;
    logic [7:0] pfl_two_d;
    logic [7:0] option_q;
    logic [7:0] option_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pin_prev_q;
    logic edge_pend_q;
    logic edge_pend_d;
    logic req_q;
    logic wake_arm_q;
    logic sleep_prev_q;
    logic vec_load_q;
    logic [12:0] vector_q;
    ief_take_type take_q;
    ief_take_type take_d;
    logic [1:0] lat_q;
    logic [1:0] lat_d;

    // =====================================================
    // APB decode
    // =====================================================
    wire setup = apb_i.psel & ~apb_i.penable;
    wire access = apb_i.psel & apb_i.penable;
    wire hit_control = addr_hit(apb_i.paddr, `IEF_OFF_CONTROL);
    wire hit_pen_one = addr_hit(apb_i.paddr, `IEF_OFF_PEN_ONE);
    wire hit_pen_two = addr_hit(apb_i.paddr, `IEF_OFF_PEN_TWO);
    wire hit_pfl_one = addr_hit(apb_i.paddr, `IEF_OFF_PFL_ONE);
    wire hit_pfl_two = addr_hit(apb_i.paddr, `IEF_OFF_PFL_TWO);
    wire hit_option = addr_hit(apb_i.paddr, `IEF_OFF_OPTION);
    wire hit_status = addr_hit(apb_i.paddr, `IEF_OFF_STATUS);
    wire hit_any = hit_control | hit_pen_one | hit_pen_two | hit_pfl_one | hit_pfl_two | hit_option | hit_status;
    wire wr = access & apb_i.pwrite & hit_any;
    wire [7:0] wbyte = apb_i.pwdata[7:0];
    wire wr_control = wr & hit_control;
    wire wr_pen_one = wr & hit_pen_one;
    wire wr_pen_two = wr & hit_pen_two;
    wire wr_pfl_one = wr & hit_pfl_one;
    wire wr_pfl_two = wr & hit_pfl_two;
    wire wr_option = wr & hit_option;

    // Zero wait states: read data is captured in setup so prdata comes from a flop
    assign apb_o.pready = 1'b1;
    assign apb_o.pslverr = access & ~hit_any;
    assign apb_o.prdata = prdata_q;

    // =====================================================
    // External pin edge detection
    // =====================================================
    wire ext_edge_select = option_q[`IEF_BIT_EDGE];
    wire analog_select = option_q[`IEF_BIT_ANALOG];
    // Analog pins read zero, so they can never produce an edge
    wire pin_digital = pin_sync & ~analog_select;
    wire pin_rise = pin_digital & ~pin_prev_q;
    wire pin_fall = ~pin_digital & pin_prev_q;
    wire edge_hit = ext_edge_select ? pin_rise : pin_fall;
    // Flag may only change in the Q4-Q1 window; earlier edges wait here
    wire flag_window = q4 | q1;
    wire ext_set = (edge_hit | edge_pend_q) & flag_window;

    always_comb begin
        edge_pend_d = edge_pend_q;
        if (flag_window) begin
            edge_pend_d = 1'b0;
        end else if (edge_hit) begin
            edge_pend_d = 1'b1;
        end
    end

    // =====================================================
    // Interrupt request
    // =====================================================
    wire global_irq_enable = control_q[`IEF_BIT_GLOBAL_EN];
    wire peripheral_irq_enable = control_q[`IEF_BIT_PERIPH_EN];
    wire timer0_overflow_enable = control_q[`IEF_BIT_TIMER_EN];
    wire ext_pin_enable = control_q[`IEF_BIT_EXTE];
    wire change_detect_enable = control_q[`IEF_BIT_CDE];
    wire timer0_overflow_flag = control_q[`IEF_BIT_T0F];
    wire ext_pin_flag = control_q[`IEF_BIT_EXTF];
    wire change_detect_flag = control_q[`IEF_BIT_CDF];

    wire periph_term = any_term(pfl_one_q, pen_one_q) | any_term(pfl_two_q, pen_two_q);
    wire ext_term = ext_pin_flag & ext_pin_enable;
    wire core_term = (timer0_overflow_flag & timer0_overflow_enable) | ext_term
        | (change_detect_flag & change_detect_enable);
    wire masked_any = core_term | (periph_term & peripheral_irq_enable);
    wire request = masked_any & global_irq_enable;

    // Taking sequence: sampled request counted over whole instruction cycles
    // A request withdrawn in the very take cycle must not be taken either
    wire take_fire = (take_q == IEF_WAIT) & q1 & req_q & request & (lat_q == 2'(`IEF_LATENCY_TCY - 1));

    always_comb begin
        take_d = take_q;
        lat_d = lat_q;
        unique case (take_q)
            IEF_IDLE: begin
                if (q1 & request) begin
                    take_d = IEF_WAIT;
                    lat_d = 2'h0;
                end
            end
            IEF_WAIT: begin
                // A request withdrawn before the take is dropped, not serviced late
                if (~global_irq_enable | ~masked_any) begin
                    take_d = IEF_IDLE;
                end else if (take_fire) begin
                    take_d = IEF_IDLE;
                end else if (q1) begin
                    lat_d = lat_q + 2'h1;
                end
            end
        endcase
    end

    // =====================================================
    // Register next values
    // =====================================================
    // Hardware sets win over software writes in the same cycle
    always_comb begin
        control_d = wr_control ? wbyte : control_q;
        if (return_from_irq_i) begin
            control_d[`IEF_BIT_GLOBAL_EN] = 1'b1;
        end
        if (take_fire) begin
            control_d[`IEF_BIT_GLOBAL_EN] = 1'b0;
        end
        control_d[`IEF_BIT_T0F] = control_d[`IEF_BIT_T0F] | evt_i.timer0_rollover;
        control_d[`IEF_BIT_EXTF] = control_d[`IEF_BIT_EXTF] | ext_set;
        control_d[`IEF_BIT_CDF] = control_d[`IEF_BIT_CDF] | evt_i.change_detect;
    end

    assign pen_one_d = wr_pen_one ? (wbyte & `IEF_MASK_ONE) : pen_one_q;
    assign pen_two_d = wr_pen_two ? (wbyte & `IEF_MASK_TWO) : pen_two_q;
    assign pfl_one_d = ((wr_pfl_one ? wbyte : pfl_one_q) | evt_i.periph_one) & `IEF_MASK_ONE;
    assign pfl_two_d = ((wr_pfl_two ? wbyte : pfl_two_q) | evt_i.periph_two) & `IEF_MASK_TWO;
    assign option_d = wr_option ? (wbyte & 8'h03) : option_q;

    wire [7:0] status_byte = {4'h0, pin_digital, wake_arm_q, (take_q == IEF_WAIT), req_q};

    always_comb begin
        prdata_d = prdata_q;
        if (setup & ~apb_i.pwrite) begin
            prdata_d = 32'h00000000;
            if (hit_control) begin
                prdata_d = {24'h000000, control_q};
            end else if (hit_pen_one) begin
                prdata_d = {24'h000000, pen_one_q};
            end else if (hit_pen_two) begin
                prdata_d = {24'h000000, pen_two_q};
            end else if (hit_pfl_one) begin
                prdata_d = {24'h000000, pfl_one_q};
            end else if (hit_pfl_two) begin
                prdata_d = {24'h000000, pfl_two_q};
            end else if (hit_option) begin
                prdata_d = {24'h000000, option_q};
            end else if (hit_status) begin
                prdata_d = {24'h000000, status_byte};
            end
        end
    end

    // =====================================================
    // Sleep wake-up
    // =====================================================
    // Pin enable is captured on the way into sleep; enabling it later does not wake
    wire sleep_entry = sleep_i & ~sleep_prev_q;
    wire other_wake = (timer0_overflow_flag & timer0_overflow_enable)
        | (change_detect_flag & change_detect_enable) | (periph_term & peripheral_irq_enable);
    wire wake = sleep_i & ((ext_term & wake_arm_q) | other_wake);

    // =====================================================
    // Flops
    // =====================================================
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            control_q <= `IEF_RST_CONTROL;
            pen_one_q <= `IEF_RST_PERIPH;
            pen_two_q <= `IEF_RST_PERIPH;
            pfl_one_q <= `IEF_RST_PERIPH;
            pfl_two_q <= `IEF_RST_PERIPH;
            option_q <= `IEF_RST_OPTION;
            prdata_q <= 32'h00000000;
        end else begin
            control_q <= control_d;
            pen_one_q <= pen_one_d;
            pen_two_q <= pen_two_d;
            pfl_one_q <= pfl_one_d;
            pfl_two_q <= pfl_two_d;
            option_q <= option_d;
            prdata_q <= prdata_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pin_prev_q <= 1'b0;
            edge_pend_q <= 1'b0;
            sleep_prev_q <= 1'b0;
            wake_arm_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_digital;
            edge_pend_q <= edge_pend_d;
            sleep_prev_q <= sleep_i;
            if (sleep_entry) begin
                wake_arm_q <= ext_pin_enable;
            end else if (~sleep_i) begin
                wake_arm_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            req_q <= 1'b0;
            take_q <= IEF_IDLE;
            lat_q <= 2'h0;
            vec_load_q <= 1'b0;
            vector_q <= 13'h0000;
        end else begin
            if (q1) begin
                req_q <= request;
            end
            take_q <= take_d;
            lat_q <= lat_d;
            vec_load_q <= take_fire;
            if (take_fire) begin
                vector_q <= `IEF_VECTOR;
            end
        end
    end

    assign core_o.irq_req = req_q;
    assign core_o.vector_load = vec_load_q;
    assign core_o.vector = vector_q;
    assign core_o.wake = wake;
    assign pin_level_o = pin_digital;

    // =====================================================
    // Assertions
    // =====================================================
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    rise_sets_flag_a: assert property (ext_edge_select & pin_rise & ~wr_control |-> ##[1:4] ext_pin_flag)
        else $error("rising edge did not set pin flag");
    analog_no_edge_a: assert property (analog_select |-> ~edge_hit)
        else $error("analog pin produced an edge");
    flag_window_a: assert property ($rose(ext_pin_flag) && !$past(wr_control) |-> $past(flag_window))
        else $error("pin flag set outside Q4-Q1");
    pin_gate_a: assert property (~ext_pin_enable & ~periph_term & ~timer0_overflow_flag
        & ~change_detect_flag |-> ~request)
        else $error("disabled pin raised request");
    global_gate_a: assert property (~global_irq_enable |-> ~request)
        else $error("request with global enable low");
    periph_gate_a: assert property (~peripheral_irq_enable & ~core_term |-> ~masked_any)
        else $error("peripheral request with peripheral enable low");
    take_latency_a: assert property ($rose(take_fire) |-> $past(q1 & request, 12)
        & ($past(take_q, 12) == IEF_IDLE) & $past(req_q, 4))
        else $error("take not three instruction cycles after sample");
    take_clears_a: assert property (take_fire & ~return_from_irq_i |=> ~global_irq_enable ##0 vec_load_q
        ##0 (vector_q == `IEF_VECTOR))
        else $error("take did not clear global enable and load vector");
    unimpl_zero_a: assert property ((pen_one_q & ~`IEF_MASK_ONE) == 8'h00
        && (pfl_two_q & ~`IEF_MASK_TWO) == 8'h00)
        else $error("unimplemented bits not zero");
    event_sets_a: assert property (evt_i.timer0_rollover |=> timer0_overflow_flag)
        else $error("rollover event lost");
    wake_arm_a: assert property (sleep_i & ~wake_arm_q & ~other_wake |-> ~wake)
        else $error("pin woke core without prior enable");
endmodule
`default_nettype wire

// ===== dv/ief_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module ief_core_model
    import ief_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire ief_core_type core_i,
    input wire ief_evt_type evt_req_i,
    input wire logic [7:0] svc_cycles_i,
    output ief_evt_type evt_o,
    output logic return_from_irq_o
);
    // ==========================================
    // Event sources and service routine
    // ==========================================
    ief_evt_type evt_q;
    logic [7:0] svc_cnt_q;

    // Sources fire regardless of any enable; one clock wide
    always_ff @(posedge clock_i) begin
        evt_q <= sys_rst_i ? '0 : evt_req_i;
    end
    assign evt_o = evt_q;

    // Zero service length means the routine never returns
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            svc_cnt_q <= 8'h00;
        end else if (core_i.vector_load) begin
            svc_cnt_q <= svc_cycles_i;
        end else if (svc_cnt_q != 8'h00) begin
            svc_cnt_q <= svc_cnt_q - 8'h01;
        end
    end
    assign return_from_irq_o = (svc_cnt_q == 8'h01);
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ief_map.svh"
module tb
    import ief_pkg::*;
;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic se;
    } ief_row_type;

    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    ief_apb_req_type apb_i = '0;
    ief_apb_rsp_type apb_o;
    logic ext_irq_pin_i = 1'b0;
    ief_evt_type evt_req = '0;
    ief_evt_type evt_i;
    logic sleep_i = 1'b0;
    logic return_from_irq_i;
    ief_core_type core_o;
    logic pin_level_o;
    logic [7:0] svc_cycles = 8'h00;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int n_checks = 0;
    int t;
    ief_row_type rows [13] = '{
        '{`IEF_OFF_PEN_ONE, 32'hFF, 32'h73, 1'b0},
        '{`IEF_OFF_PEN_TWO, 32'hFF, 32'hB2, 1'b0},
        '{`IEF_OFF_PFL_ONE, 32'hFF, 32'h73, 1'b0},
        '{`IEF_OFF_PFL_TWO, 32'hFF, 32'hB2, 1'b0},
        '{`IEF_OFF_CONTROL, 32'h7F, 32'h7F, 1'b0},
        '{`IEF_OFF_CONTROL, 32'h00, 32'h00, 1'b0},
        '{`IEF_OFF_PFL_ONE, 32'h00, 32'h00, 1'b0},
        '{`IEF_OFF_PFL_TWO, 32'h00, 32'h00, 1'b0},
        '{`IEF_OFF_PEN_ONE, 32'h00, 32'h00, 1'b0},
        '{`IEF_OFF_PEN_TWO, 32'h00, 32'h00, 1'b0},
        '{`IEF_OFF_OPTION, 32'h03, 32'h03, 1'b0},
        '{`IEF_OFF_STATUS, 32'hFF, 32'h00, 1'b0},
        '{8'h1C, 32'hFF, 32'h00, 1'b1}
    };

    always #4 clock_i = ~clock_i;

    ief_top i_ief_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .apb_i(apb_i), .apb_o(apb_o),
        .ext_irq_pin_i(ext_irq_pin_i), .evt_i(evt_i), .sleep_i(sleep_i),
        .return_from_irq_i(return_from_irq_i), .core_o(core_o), .pin_level_o(pin_level_o));
    ief_core_model i_ief_core_model (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .core_i(core_o),
        .evt_req_i(evt_req), .svc_cycles_i(svc_cycles), .evt_o(evt_i),
        .return_from_irq_o(return_from_irq_i));

    // ==========================================
    // Helpers
    // ==========================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // Master waits for pready rather than assuming zero wait states
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        apb_i <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clock_i);
        apb_i.penable <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (apb_o.pready !== 1'b1 && n < 64);
        if (n == 64) n_fail++;
        rd = apb_o.prdata;
        err = apb_o.pslverr;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic wait_irq();
        t = 0;
        while (core_o.irq_req !== 1'b1 && t < 16) begin
            @(posedge clock_i);
            t++;
        end
    endtask

    task automatic summarize();
        $display("checks=%0d failures=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #160000;
        n_fail++;
        summarize();
    end

    // ==========================================
    // Sequence
    // ==========================================
    initial begin
        cyc(12);
        sys_rst_i <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            chk1(err, rows[i].se);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].e);
        end
        // Second reset in mid-run
        apb(1'b1, `IEF_OFF_CONTROL, 32'h7F);
        apb(1'b1, `IEF_OFF_PEN_ONE, 32'h73);
        apb(1'b1, `IEF_OFF_OPTION, 32'h01);
        sys_rst_i <= 1'b1;
        cyc(2);
        chk({16'h0, core_o}, 32'h0);
        sys_rst_i <= 1'b0;
        rchk(`IEF_OFF_CONTROL, 32'h00);
        rchk(`IEF_OFF_PEN_ONE, 32'h00);
        rchk(`IEF_OFF_OPTION, 32'h02);
        // Analog pin: no flag, reads low
        ext_irq_pin_i <= 1'b1;
        cyc(12);
        chk1(pin_level_o, 1'b0);
        rchk(`IEF_OFF_CONTROL, 32'h00);
        // Both edge polarities, wrong edge ignored
        for (int e = 0; e < 2; e++) begin
            ext_irq_pin_i <= ~e[0];
            apb(1'b1, `IEF_OFF_OPTION, {31'h0, e[0]});
            cyc(8);
            apb(1'b1, `IEF_OFF_CONTROL, 32'h0);
            ext_irq_pin_i <= e[0];
            cyc(12);
            chk1(pin_level_o, e[0]);
            rchk(`IEF_OFF_CONTROL, 32'h02);
            apb(1'b1, `IEF_OFF_CONTROL, 32'h0);
            ext_irq_pin_i <= ~e[0];
            cyc(12);
            rchk(`IEF_OFF_CONTROL, 32'h00);
        end
        // Timer flag, masking, latency and take
        ext_irq_pin_i <= 1'b0;
        evt_req.timer0_rollover <= 1'b1;
        cyc(1);
        evt_req.timer0_rollover <= 1'b0;
        rchk(`IEF_OFF_CONTROL, 32'h04);
        apb(1'b1, `IEF_OFF_CONTROL, 32'h84);
        cyc(16);
        chk1(core_o.irq_req, 1'b0);
        svc_cycles <= 8'd24;
        apb(1'b1, `IEF_OFF_CONTROL, 32'hA4);
        wait_irq();
        chk1(core_o.irq_req, 1'b1);
        t = 0;
        while (core_o.vector_load !== 1'b1 && t < 40) begin
            @(posedge clock_i);
            t++;
        end
        chk(t, 32'h0000000C);
        chk({19'h0, core_o.vector}, 32'h00000004);
        rchk(`IEF_OFF_CONTROL, 32'h24);
        apb(1'b1, `IEF_OFF_CONTROL, 32'h20);
        cyc(30);
        rchk(`IEF_OFF_CONTROL, 32'hA0);
        chk1(core_o.irq_req, 1'b0);
        apb(1'b1, `IEF_OFF_CONTROL, 32'h00);
        svc_cycles <= 8'h00;
        // Peripheral flags and the two gates
        evt_req <= '{1'b0, 1'b1, 8'hFF, 8'hFF};
        cyc(1);
        evt_req <= '0;
        rchk(`IEF_OFF_PFL_ONE, 32'h73);
        rchk(`IEF_OFF_PFL_TWO, 32'hB2);
        rchk(`IEF_OFF_CONTROL, 32'h01);
        apb(1'b1, `IEF_OFF_PFL_ONE, 32'h0);
        apb(1'b1, `IEF_OFF_PEN_TWO, 32'h80);
        apb(1'b1, `IEF_OFF_CONTROL, 32'h40);
        cyc(12);
        chk1(core_o.irq_req, 1'b0);
        apb(1'b1, `IEF_OFF_CONTROL, 32'h80);
        cyc(12);
        chk1(core_o.irq_req, 1'b0);
        apb(1'b1, `IEF_OFF_CONTROL, 32'hC0);
        wait_irq();
        chk1(core_o.irq_req, 1'b1);
        // Sampled request with the take still counting
        rchk(`IEF_OFF_STATUS, 32'h03);
        apb(1'b1, `IEF_OFF_CONTROL, 32'h00);
        apb(1'b1, `IEF_OFF_PFL_TWO, 32'h0);
        apb(1'b1, `IEF_OFF_PEN_TWO, 32'h0);
        // Wake needs the pin enable armed before sleep
        apb(1'b1, `IEF_OFF_OPTION, 32'h01);
        sleep_i <= 1'b1;
        cyc(2);
        apb(1'b1, `IEF_OFF_CONTROL, 32'h10);
        ext_irq_pin_i <= 1'b1;
        cyc(12);
        chk1(core_o.wake, 1'b0);
        sleep_i <= 1'b0;
        ext_irq_pin_i <= 1'b0;
        apb(1'b1, `IEF_OFF_CONTROL, 32'h10);
        sleep_i <= 1'b1;
        cyc(2);
        ext_irq_pin_i <= 1'b1;
        cyc(12);
        chk1(core_o.wake, 1'b1);
        // Armed wake and digital pin level show in status
        rchk(`IEF_OFF_STATUS, 32'h0C);
        apb(1'b1, `IEF_OFF_CONTROL, 32'h02);
        cyc(1);
        chk1(core_o.wake, 1'b0);
        sleep_i <= 1'b0;
        cyc(4);
        summarize();
    end
endmodule
`default_nettype wire
